// ### xmii_tx_pkg.sv
// Shared types and constants for the xMII transmit port
package xmii_tx_pkg;

  // Interface standards
  typedef enum logic [1:0] {
    MODE_MII  = 2'b00,
    MODE_RMII = 2'b01,
    MODE_GMII = 2'b10,
    MODE_TBI  = 2'b11
  } tx_mode_e;

  // Launch state
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } tx_state_e;

  // One beat from the user: byte (GMII/MII/RMII) or 10-bit code group (TBI)
  typedef struct packed {
    logic [9:0] code;
    logic       err;
    logic       last;
  } tx_beat_s;

  localparam int BEAT_W = $bits(tx_beat_s);

  // Pin levels driven onto the transmit lines
  typedef struct packed {
    logic [7:0] lanes;
    logic       frame_valid;
    logic       error_flag;
  } tx_pins_s;

  // Timing
  localparam int SYS_PERIOD_NS  = 5;
  localparam int TXCLK_FREQ_MHZ = 25;
  localparam int TXCLK_PERIOD_NS = 1000 / TXCLK_FREQ_MHZ;
  localparam int GTX_FREQ_MHZ   = 125;
  localparam int GTX_PERIOD_NS  = 1000 / GTX_FREQ_MHZ;
  localparam int TXCLK_HALF_CYC = (TXCLK_PERIOD_NS / 2) / SYS_PERIOD_NS;
  localparam int GTX_HALF_RAW   = (GTX_PERIOD_NS / 2) / SYS_PERIOD_NS;
  localparam int GTX_HALF_CYC   = (GTX_HALF_RAW < 1) ? 1 : GTX_HALF_RAW;

  // Symbol index of the last symbol of a beat per mode
  localparam logic [1:0] LAST_IDX_MII  = 2'd1;
  localparam logic [1:0] LAST_IDX_RMII = 2'd3;
  localparam logic [1:0] LAST_IDX_WIDE = 2'd0;

  // Buffer
  localparam int BUF_DEPTH = 2;

  // Reset values
  localparam tx_pins_s PINS_IDLE = '0;

endpackage

// ### tx_beat_buffer.sv
// Two-entry beat buffer with valid/ready on both sides
`timescale 1ns/1ps
module tx_beat_buffer #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  // Handshakes
  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign next_count = count + {1'b0, push} - {1'b0, pop};
  assign out_data   = mem[rd_ptr];

  // Storage and pointers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= next_count;
    end
  end

  // Registered flags
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      in_ready  <= (next_count != 2'd2);
      out_valid <= (next_count != 2'd0);
    end
  end

  AST_BUF_NO_OVERFLOW: assert property (@(posedge clk_sys) disable iff (srst)
    count <= 2'd2)
    else $error("buffer count above two");

endmodule

// ### xmii_transmit_port.sv
// Transmit side of one xMII port: buffering, serialising and pin timing
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// RL1: MII drives data only on lanes 3..0, upper lanes stay low.
// RL2: RMII drives data only on lanes 1..0.
// RL3: MII data launched on rising edge of the port transmit clock.
// RL4: RMII data and frame valid timed by rising reference clock edge.
// RL5: GMII and TBI data timed by rising edge of generated gigabit clock.
// RL6: Frame valid rises with the first preamble symbol of a packet.
// RL7: Frame valid held for the whole packet, dropped after final symbol. The code also drops it when the buffer runs empty before the last beat.
// RL8: In TBI the frame valid pin carries code-group bit 8.
// RL9: Transmit clock is 25 MHz: input as MAC, driven in PHY emulation.
// RL10: Error with frame valid in GMII/MII marks an invalid symbol.
// RL11: Between packets the data lanes rest low.
module xmii_transmit_port
  import xmii_tx_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  // Configuration
  input  wire xmii_tx_pkg::tx_mode_e mode,
  input  wire logic                 phy_emulation,
  // User beat stream
  input  wire logic                 beat_valid,
  output logic                      beat_ready,
  input  wire xmii_tx_pkg::tx_beat_s beat,
  // Link clocks
  input  wire logic                 port_tx_clock_in,
  output logic                      port_tx_clock_out,
  output logic                      port_tx_clock_oe,
  input  wire logic                 port_rmii_ref_clock,
  output logic                      port_gigabit_tx_clock,
  // Transmit pins
  output logic [7:0]                port_tx_lanes,
  output logic                      port_tx_frame_valid,
  output logic                      port_tx_error_flag
);
  import xmii_tx_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] clk_level;
  logic       tick_txc_pin;
  logic       tick_ref;
  logic [2:0] txc_div;
  logic [2:0] gtx_div;
  logic       own_txc_rise;
  logic       gtx_rise;
  logic       tick_txc;
  logic       tick;
  logic       buf_valid;
  logic       buf_ready;
  tx_beat_s   buf_beat;
  tx_state_e  state;
  tx_state_e  next_state;
  tx_beat_s   cur;
  tx_beat_s   next_cur;
  logic [1:0] idx;
  logic [1:0] next_idx;
  logic [1:0] last_idx;
  logic       pop;
  logic       launch;
  tx_pins_s   next_pins;

  //////////////////////////////////////////////////////////////////////////////
  // Buffer in the data path
  tx_beat_buffer #(
    .WIDTH(BEAT_W)
  ) u_buffer (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .in_valid (beat_valid),
    .in_ready (beat_ready),
    .in_data  (beat),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data (buf_beat)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Three-flop sampling of the external link clocks
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1     <= 2'h0;
      sync2     <= 2'h0;
      sync3     <= 2'h0;
      clk_level <= 2'h0;
    end else begin
      sync1 <= {port_rmii_ref_clock, port_tx_clock_in};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 2; i++) begin
        if (sync2[i] == sync3[i]) begin
          clk_level[i] <= sync3[i];
        end
      end
    end
  end

  // Rising edge accepted once second and third stage agree
  assign tick_txc_pin = (sync2[0] == sync3[0]) && sync3[0] && !clk_level[0];
  assign tick_ref     = (sync2[1] == sync3[1]) && sync3[1] && !clk_level[1];

  //////////////////////////////////////////////////////////////////////////////
  // Own 25 MHz transmit clock for PHY emulation
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      txc_div           <= 3'h0;
      port_tx_clock_out <= 1'b0;
      port_tx_clock_oe  <= 1'b0;
    end else begin
      port_tx_clock_oe <= phy_emulation; // RL9
      if (!phy_emulation) begin
        txc_div           <= 3'h0;
        port_tx_clock_out <= 1'b0;
      end else if (txc_div == 3'(TXCLK_HALF_CYC - 1)) begin
        txc_div           <= 3'h0;
        port_tx_clock_out <= ~port_tx_clock_out; // RL9
      end else begin
        txc_div <= txc_div + 3'h1;
      end
    end
  end

  assign own_txc_rise = phy_emulation && !port_tx_clock_out &&
                        (txc_div == 3'(TXCLK_HALF_CYC - 1));

  // Generated gigabit clock, running only in GMII and TBI
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gtx_div               <= 3'h0;
      port_gigabit_tx_clock <= 1'b0;
    end else if (mode != MODE_GMII && mode != MODE_TBI) begin
      gtx_div               <= 3'h0;
      port_gigabit_tx_clock <= 1'b0;
    end else if (gtx_div == 3'(GTX_HALF_CYC - 1)) begin
      gtx_div               <= 3'h0;
      port_gigabit_tx_clock <= ~port_gigabit_tx_clock;
    end else begin
      gtx_div <= gtx_div + 3'h1;
    end
  end

  assign gtx_rise = (mode == MODE_GMII || mode == MODE_TBI) &&
                    !port_gigabit_tx_clock && (gtx_div == 3'(GTX_HALF_CYC - 1));

  // Launch edge per mode
  assign tick_txc = phy_emulation ? own_txc_rise : tick_txc_pin;
  always_comb begin
    unique case (mode)
      MODE_MII:  tick = tick_txc; // RL3
      MODE_RMII: tick = tick_ref; // RL4
      MODE_GMII: tick = gtx_rise; // RL5
      MODE_TBI:  tick = gtx_rise; // RL5
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Symbol sequencing
  always_comb begin
    unique case (mode)
      MODE_MII:  last_idx = LAST_IDX_MII;
      MODE_RMII: last_idx = LAST_IDX_RMII;
      MODE_GMII: last_idx = LAST_IDX_WIDE;
      MODE_TBI:  last_idx = LAST_IDX_WIDE;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_idx   = idx;
    pop        = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (buf_valid) begin
          pop        = 1'b1;
          next_cur   = buf_beat;
          next_idx   = 2'h0;
          next_state = ST_SEND; // RL6
        end
      end
      ST_SEND: begin
        if (idx != last_idx) begin
          next_idx = idx + 2'h1; // RL7
        end else if (!cur.last && buf_valid) begin
          pop      = 1'b1;
          next_cur = buf_beat;
          next_idx = 2'h0; // RL7
        end else begin
          next_state = ST_IDLE; // RL7
        end
      end
    endcase
  end

  assign buf_ready = tick && pop;
  assign launch    = tick && (next_state == ST_SEND);

  // Pin levels for the symbol about to be launched
  always_comb begin
    next_pins = PINS_IDLE; // RL11
    if (next_state == ST_SEND) begin
      unique case (mode)
        MODE_MII: begin
          next_pins.lanes[3:0] = next_idx[0] ? next_cur.code[7:4]
                                             : next_cur.code[3:0]; // RL1
          next_pins.frame_valid = 1'b1; // RL6
          next_pins.error_flag  = next_cur.err; // RL10
        end
        MODE_RMII: begin
          next_pins.lanes[1:0]  = next_cur.code[{next_idx, 1'b0} +: 2]; // RL2
          next_pins.frame_valid = 1'b1; // RL6
        end
        MODE_GMII: begin
          next_pins.lanes       = next_cur.code[7:0];
          next_pins.frame_valid = 1'b1; // RL6
          next_pins.error_flag  = next_cur.err; // RL10
        end
        MODE_TBI: begin
          next_pins.lanes       = next_cur.code[7:0];
          next_pins.frame_valid = next_cur.code[8]; // RL8
          next_pins.error_flag  = next_cur.code[9];
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      cur   <= '0;
      idx   <= 2'h0;
    end else if (tick) begin
      state <= next_state;
      cur   <= next_cur;
      idx   <= next_idx;
    end
  end

  // Output pins, updated only on the launch edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port_tx_lanes       <= 8'h00;
      port_tx_frame_valid <= 1'b0;
      port_tx_error_flag  <= 1'b0;
    end else if (tick) begin
      port_tx_lanes       <= next_pins.lanes; // RL11
      port_tx_frame_valid <= next_pins.frame_valid; // RL7
      port_tx_error_flag  <= next_pins.error_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_final_symbol;
    tick && state == ST_SEND && idx == last_idx && (cur.last || !buf_valid);
  endsequence

  sequence seq_frame_start;
    tick && state == ST_IDLE && buf_valid;
  endsequence

  AST_MII_UPPER_LOW: assert property (@(posedge clk_sys) disable iff (srst) // RL1
    mode == MODE_MII && $stable(mode) |-> port_tx_lanes[7:4] == 4'h0)
    else $error("MII upper lanes not low");

  AST_RMII_UPPER_LOW: assert property (@(posedge clk_sys) disable iff (srst) // RL2
    mode == MODE_RMII && $stable(mode) |-> port_tx_lanes[7:2] == 6'h00)
    else $error("RMII upper lanes not low");

  AST_MII_EDGE: assert property (@(posedge clk_sys) disable iff (srst) // RL3
    mode == MODE_MII && $past(mode) == MODE_MII && !$stable(port_tx_frame_valid)
    |-> $past(tick_txc))
    else $error("MII frame valid moved off transmit clock edge");

  AST_RMII_EDGE: assert property (@(posedge clk_sys) disable iff (srst) // RL4
    mode == MODE_RMII && $past(mode) == MODE_RMII && !$stable(port_tx_lanes)
    |-> $past(tick_ref))
    else $error("RMII lanes moved off reference clock edge");

  AST_GTX_EDGE: assert property (@(posedge clk_sys) disable iff (srst) // RL5
    mode == MODE_GMII && $past(mode) == MODE_GMII && !$stable(port_tx_lanes)
    |-> $past(gtx_rise) && port_gigabit_tx_clock)
    else $error("GMII lanes moved off gigabit clock edge");

  AST_FRAME_START: assert property (@(posedge clk_sys) disable iff (srst) // RL6
    ((mode == MODE_GMII && $stable(mode)) and seq_frame_start)
    |=> port_tx_frame_valid && port_tx_lanes == $past(buf_beat.code[7:0]))
    else $error("frame valid not raised with first symbol");

  AST_FRAME_END: assert property (@(posedge clk_sys) disable iff (srst) // RL7
    ((mode != MODE_TBI && $stable(mode)) and seq_final_symbol)
    |=> !port_tx_frame_valid ##1 !port_tx_frame_valid)
    else $error("frame valid not dropped after final symbol");

  AST_FRAME_HOLD: assert property (@(posedge clk_sys) disable iff (srst) // RL7
    mode != MODE_TBI && $stable(mode) && state == ST_SEND && !tick
    |=> $stable(port_tx_frame_valid))
    else $error("frame valid moved inside a symbol");

  AST_TBI_BIT8: assert property (@(posedge clk_sys) disable iff (srst) // RL8
    mode == MODE_TBI && $stable(mode) && launch
    |=> port_tx_frame_valid == $past(next_cur.code[8]))
    else $error("TBI frame valid pin not code bit 8");

  AST_TXCLK_DIR: assert property (@(posedge clk_sys) disable iff (srst) // RL9
    phy_emulation ##1 phy_emulation |-> port_tx_clock_oe)
    else $error("transmit clock not driven in PHY emulation");

  AST_ERROR_SYMBOL: assert property (@(posedge clk_sys) disable iff (srst) // RL10
    mode == MODE_MII && $stable(mode) && launch && next_cur.err
    |=> port_tx_error_flag && port_tx_frame_valid)
    else $error("error symbol not marked");

  AST_IDLE_LOW: assert property (@(posedge clk_sys) disable iff (srst) // RL11
    mode != MODE_TBI && $stable(mode) && state == ST_IDLE && !$past(tick)
    |-> port_tx_lanes == 8'h00 && !port_tx_error_flag)
    else $error("idle lanes not low");

endmodule

// ### xmii_phy_model.sv
// Behavioural PHY: makes the transmit and reference link clocks and captures the transmit pins
`timescale 1ns/1ps
module xmii_phy_model (
  // Configuration and clocks
  input  wire xmii_tx_pkg::tx_mode_e mode,
  input  wire logic                  tx_clock_wire,
  input  wire logic                  gtx_clock,
  output logic                       phy_tx_clock,
  output logic                       ref_clock,
  // Transmit pins
  input  wire logic [7:0]            lanes,
  input  wire logic                  frame_valid,
  input  wire logic                  error_flag
);
  import xmii_tx_pkg::*;
  logic [9:0] rx_q[$];
  logic       smp_clk;
  //////////////////////////////////////////////////////////////////////////////
  // Free running link clocks, phase unrelated to the system clock
  initial begin
    phy_tx_clock = 1'b0;
    ref_clock = 1'b0;
    #3;
    forever begin
      #80;
      phy_tx_clock = ~phy_tx_clock;
      ref_clock = ~ref_clock;
    end
  end
  // Sampling edge follows the interface standard
  always_comb begin
    case (mode)
      MODE_MII:  smp_clk = tx_clock_wire;
      MODE_RMII: smp_clk = ref_clock;
      default:   smp_clk = gtx_clock;
    endcase
  end
  // Capture every symbol that is not idle, mid-symbol, clear of the launch edge
  always @(negedge smp_clk) begin
    if (frame_valid || error_flag || lanes != 8'h00) begin
      rx_q.push_back({error_flag, frame_valid, lanes});
    end
  end
endmodule

// ### testbench.sv
// Self-checking bench for the xMII transmit port
`timescale 1ns/1ps
module testbench;
  import xmii_tx_pkg::*;
  logic       clk_sys;
  logic       srst;
  tx_mode_e   mode;
  logic       phy_emulation;
  logic       beat_valid;
  logic       beat_ready;
  tx_beat_s   beat;
  logic       port_tx_clock_in;
  logic       port_tx_clock_out;
  logic       port_tx_clock_oe;
  logic       port_rmii_ref_clock;
  logic       port_gigabit_tx_clock;
  logic [7:0] port_tx_lanes;
  logic       port_tx_frame_valid;
  logic       port_tx_error_flag;
  logic       phy_tx_clock;
  int         miscompares = 0;
  int         total_checks = 0;
  // Clock pin level: whoever enables its driver wins
  assign port_tx_clock_in = port_tx_clock_oe ? port_tx_clock_out : phy_tx_clock;
  //////////////////////////////////////////////////////////////////////////////
  xmii_transmit_port xmii_transmit_port_i (
    .clk_sys(clk_sys), .srst(srst), .mode(mode), .phy_emulation(phy_emulation),
    .beat_valid(beat_valid), .beat_ready(beat_ready), .beat(beat),
    .port_tx_clock_in(port_tx_clock_in), .port_tx_clock_out(port_tx_clock_out),
    .port_tx_clock_oe(port_tx_clock_oe), .port_rmii_ref_clock(port_rmii_ref_clock),
    .port_gigabit_tx_clock(port_gigabit_tx_clock), .port_tx_lanes(port_tx_lanes),
    .port_tx_frame_valid(port_tx_frame_valid), .port_tx_error_flag(port_tx_error_flag));
  xmii_phy_model xmii_phy_model_i (
    .mode(mode), .tx_clock_wire(port_tx_clock_in), .gtx_clock(port_gigabit_tx_clock),
    .phy_tx_clock(phy_tx_clock), .ref_clock(port_rmii_ref_clock), .lanes(port_tx_lanes),
    .frame_valid(port_tx_frame_valid), .error_flag(port_tx_error_flag));
  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Offer one beat, hold it until taken; counts refused cycles
  task automatic put(input logic [9:0] c, input logic e, input logic l, output int waits);
    waits = 0;
    beat <= {c, e, l};
    beat_valid <= 1'b1;
    @(negedge clk_sys);
    while (beat_ready !== 1'b1 && waits < 4000) begin
      waits++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask
  // Send one packet in a mode and compare what the PHY captured
  task automatic xfer(input tx_mode_e m, input logic [9:0] c[], input logic [7:0] e,
                      output int refused);
    int w, n, k;
    logic [9:0] x;
    w = (m == MODE_MII) ? 4 : (m == MODE_RMII) ? 2 : 8;
    @(posedge clk_sys);
    mode <= m;
    repeat (400) @(posedge clk_sys);
    xmii_phy_model_i.rx_q.delete();
    refused = 0;
    for (int i = 0; i < c.size(); i++) begin
      put(c[i], e[i], i == c.size() - 1, n);
      refused += n;
    end
    beat_valid <= 1'b0;
    n = 0;
    while (xmii_phy_model_i.rx_q.size() < c.size() * 8 / w && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (100) @(negedge clk_sys);
    k = 0;
    for (int i = 0; i < c.size(); i++) begin
      for (int j = 0; j < 8 / w; j++) begin
        x = {e[i] & (m != MODE_RMII), 1'b1, 8'((c[i][7:0] >> (w * j)) & ((1 << w) - 1))};
        if (m == MODE_TBI) x = c[i];
        check("symbol", x, xmii_phy_model_i.rx_q[k]);
        k++;
      end
    end
    check("symbol count", 10'(k), 10'(xmii_phy_model_i.rx_q.size()));
    check("idle pins", 10'h000, {port_tx_error_flag, port_tx_frame_valid, port_tx_lanes});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // MII nibbles on the slow clock; buffer fills and refuses
  task automatic test_mii();
    int r;
    xfer(MODE_MII, '{10'h0a5, 10'h03c, 10'h00f, 10'h081}, 8'h02, r);
    check("refusal seen", 10'h001, 10'(r > 0));
  endtask
  // RMII dibits on the reference clock, error not carried
  task automatic test_rmii();
    int r;
    xfer(MODE_RMII, '{10'h09c, 10'h042}, 8'h01, r);
  endtask
  // GMII bytes back to back with an error byte
  task automatic test_gmii();
    int r;
    xfer(MODE_GMII, '{10'h055, 10'h0d5, 10'h077, 10'h0e1}, 8'h04, r);
  endtask
  // Ten-bit code groups on lanes, frame valid and error pins
  task automatic test_tbi();
    int r;
    xfer(MODE_TBI, '{10'h3a5, 10'h16c, 10'h2f0}, 8'h00, r);
  endtask
  // Own transmit clock in PHY emulation
  task automatic test_phy_emul();
    int n, r;
    @(posedge clk_sys);
    phy_emulation <= 1'b1;
    repeat (20) @(negedge clk_sys);
    check("clock drive", 10'h001, 10'(port_tx_clock_oe));
    n = 0;
    while (port_tx_clock_out !== 1'b0 && n < 100) begin @(negedge clk_sys); n++; end
    while (port_tx_clock_out !== 1'b1 && n < 100) begin @(negedge clk_sys); n++; end
    n = 0;
    while (port_tx_clock_out !== 1'b0 && n < 100) begin @(negedge clk_sys); n++; end
    while (port_tx_clock_out !== 1'b1 && n < 100) begin @(negedge clk_sys); n++; end
    check("own clock period", 10'(2 * TXCLK_HALF_CYC), 10'(n));
    xfer(MODE_MII, '{10'h0c3}, 8'h00, r);
    @(posedge clk_sys);
    phy_emulation <= 1'b0;
    repeat (5) @(negedge clk_sys);
    check("clock released", 10'h000, 10'(port_tx_clock_oe));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Hang guard
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    mode = MODE_MII;
    phy_emulation = 1'b0;
    beat_valid = 1'b0;
    beat = '0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("reset pins", 10'h000, {beat_ready, port_tx_frame_valid, port_tx_lanes});
    @(posedge clk_sys);
    srst <= 1'b0;
    test_mii();
    test_rmii();
    test_gmii();
    test_tbi();
    test_phy_emul();
    summarize();
  end
endmodule
